// ### rtl/agps_consts.svh
// Constants for the group priority scan sequencer: offsets, bits, timing.
// Assumes byte addressing on an 8-bit AXI4-Lite address.
`ifndef AGPS_CONSTS_SVH
`define AGPS_CONSTS_SVH
`define AGPS_NCH 8
`define AGPS_OFF_CTRL 8'h00
`define AGPS_OFF_STAT 8'h04
`define AGPS_OFF_SELA 8'h08
`define AGPS_OFF_SELB 8'h0C
`define AGPS_OFF_SELC 8'h10
`define AGPS_OFF_DIAG 8'h14
`define AGPS_OFF_RES0 8'h20
`define AGPS_OFF_RESN 8'h3C
`define AGPS_B_PGS 0
`define AGPS_B_GROUP_C_ENABLE 1
`define AGPS_B_RSCN 2
`define AGPS_B_RSM 3
`define AGPS_B_RPT 4
`define AGPS_B_DIAG 5
`define AGPS_B_IE 6
`define AGPS_B_GBIE 7
`define AGPS_CTRL_RST 8'h00
`define AGPS_SEL_RST 8'h00
`define AGPS_RESP_OK 2'h0
`define AGPS_RESP_ERR 2'h2
`define AGPS_CONV_NS 2000
`define AGPS_CLK_NS 100
`define AGPS_CONV_CYC ((`AGPS_CONV_NS + `AGPS_CLK_NS - 1) / `AGPS_CLK_NS)
`endif

// ### rtl/agps_pkg.sv
// Types shared by the scan sequencer and its conversion timer.
// Assumes the constants header is on the include path.
package agps_pkg;
  `include "agps_consts.svh"
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DIAG = 4'h2,
    ST_SEEK = 4'h4,
    ST_CONV = 4'h8
  } agps_state_t;
  // Sequencer state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0][7:0] sel;
    logic start;
    agps_state_t st;
    logic [1:0] grp;
    logic [3:0] ch;
    logic [2:0] pend;
    logic [2:0][3:0] rsm;
    logic [7:0][11:0] res;
    logic [11:0] diag_res;
    logic irq_a;
    logic irq_b;
    logic go;
    logic diag;
    logic abort;
    logic [2:0] cch;
    logic awrdy;
    logic wrdy;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } agps_seq_t;
  // Conversion timer state
  typedef struct packed {
    logic busy;
    logic [7:0] cnt;
    logic [2:0] ch;
    logic diag;
    logic done;
    logic [11:0] result;
  } agps_cnv_t;
endpackage : agps_pkg

// ### rtl/agps_conv_if.sv
// Link between the scan sequencer and the conversion timer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface agps_conv_if;
  logic go; // Start one conversion, pulse
  logic diag; // Conversion is a self-diagnosis one
  logic abort; // Drop the conversion in progress, pulse
  logic [2:0] ch; // Channel to convert
  logic done; // Conversion finished, pulse
  logic [11:0] result; // Finished result
  modport seq (output go, output diag, output abort, output ch, input done, input result);
  modport cnv (input go, input diag, input abort, input ch, output done, output result);
endinterface : agps_conv_if

// ### rtl/agps_converter.sv
// Conversion timer: holds the channel mux and times one conversion.
// Assumes sample_data is synchronous to aclk and settled at the end.
`timescale 1ns/10ps
`include "agps_consts.svh"
module agps_converter (
  input wire logic aclk,
  input wire logic aresetn,
  agps_conv_if.cnv cv,
  input wire logic [11:0] sample_data,
  output logic [2:0] mux_sel,
  output logic diag_sel
);
  agps_pkg::agps_cnv_t q_ff; // Registered state
  agps_pkg::agps_cnv_t nxt_q; // Next state

  // Next-state: a new start always wins, so an abort never kills it
  always_comb begin
    nxt_q = q_ff;
    nxt_q.done = 1'b0;
    if (cv.go) begin
      // Restart discards any unfinished work
      nxt_q.busy = 1'b1;
      nxt_q.cnt = 8'h00;
      nxt_q.ch = cv.ch;
      nxt_q.diag = cv.diag;
    end else if (cv.abort) begin
      // Partial result is thrown away
      nxt_q.busy = 1'b0;
    end else if (q_ff.busy) begin
      if (q_ff.cnt == 8'(`AGPS_CONV_CYC - 1)) begin
        nxt_q.busy = 1'b0;
        nxt_q.done = 1'b1;
        nxt_q.result = sample_data;
      end else begin
        nxt_q.cnt = q_ff.cnt + 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign cv.done = q_ff.done;
  assign cv.result = q_ff.result;
  assign mux_sel = q_ff.ch;
  assign diag_sel = q_ff.diag;
endmodule : agps_converter

// ### rtl/agps_sequencer.sv
// Group priority scan sequencer with AXI4-Lite registers.
// Assumes triggers and sample data are synchronous to aclk.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "agps_consts.svh"
module agps_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trig_a,
  input wire logic trig_b,
  input wire logic trig_c,
  input wire logic [11:0] sample_data,
  output logic [2:0] analog_input_channel,
  output logic self_diagnosis_active,
  output logic conversion_start_flag,
  output logic scan_end_irq,
  output logic group_b_scan_end_irq
);
  agps_pkg::agps_seq_t q_ff; // Registered state
  agps_pkg::agps_seq_t nxt_q; // Next state
  agps_conv_if cv (); // Link to the conversion timer

  // Lowest selected channel at or above from, 8 when none
  function automatic logic [3:0] seek_ch(input logic [7:0] m, input logic [3:0] from);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (m[i] && 4'(i) >= from) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : seek_ch

  // Conversion timer
  agps_converter u_cnv (
    .aclk(aclk),
    .aresetn(aresetn),
    .cv(cv),
    .sample_data(sample_data),
    .mux_sel(analog_input_channel),
    .diag_sel(self_diagnosis_active)
  );

  assign cv.go = q_ff.go;
  assign cv.diag = q_ff.diag;
  assign cv.abort = q_ff.abort;
  assign cv.ch = q_ff.cch;

  logic group_priority_select, group_c_enable, rscn, rsm_en, rpt, diag_en; // Control bits
  logic [1:0] low_g; // Lowest-priority group in use
  logic [2:0] trg; // Effective triggers A, B, C
  logic done_ok; // Done that belongs to the current request
  logic [3:0] nch; // Next channel to scan
  logic st_req; // Start a group scan this cycle
  logic [1:0] st_grp; // Group to start
  logic [3:0] st_from; // Channel to start from
  logic sw_wr_stat; // Software write to status

  // Sequencing, register file and bus slave
  always_comb begin
    nxt_q = q_ff;
    nxt_q.go = 1'b0;
    nxt_q.abort = 1'b0;
    nxt_q.irq_a = 1'b0;
    nxt_q.irq_b = 1'b0;
    group_priority_select = q_ff.ctrl[`AGPS_B_PGS];
    group_c_enable = q_ff.ctrl[`AGPS_B_GROUP_C_ENABLE];
    rscn = q_ff.ctrl[`AGPS_B_RSCN];
    rsm_en = q_ff.ctrl[`AGPS_B_RSM];
    rpt = q_ff.ctrl[`AGPS_B_RPT];
    diag_en = q_ff.ctrl[`AGPS_B_DIAG];
    low_g = group_c_enable ? 2'h2 : 2'h1;
    trg = {trig_c & group_c_enable, trig_b, trig_a};
    done_ok = cv.done && !q_ff.go;
    nch = seek_ch(q_ff.sel[q_ff.grp], q_ff.ch);
    st_req = 1'b0;
    st_grp = 2'h0;
    st_from = 4'h0;
    sw_wr_stat = 1'b0;

    // Bus write: take address and data in either order
    if (s_axi_awvalid && q_ff.awrdy) begin
      nxt_q.awrdy = 1'b0;
      nxt_q.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q_ff.wrdy) begin
      nxt_q.wrdy = 1'b0;
      nxt_q.wdata = s_axi_wdata;
      nxt_q.wstrb = s_axi_wstrb;
    end
    if (!q_ff.awrdy && !q_ff.wrdy && !q_ff.bvalid) begin
      // Both halves held: commit and answer
      nxt_q.bvalid = 1'b1;
      nxt_q.bresp = `AGPS_RESP_OK;
      if (q_ff.waddr == `AGPS_OFF_CTRL) begin
        if (q_ff.wstrb[0]) begin
          nxt_q.ctrl = q_ff.wdata[7:0];
        end
      end else if (q_ff.waddr == `AGPS_OFF_STAT) begin
        sw_wr_stat = q_ff.wstrb[0];
      end else if (q_ff.waddr == `AGPS_OFF_SELA) begin
        if (q_ff.wstrb[0]) begin
          nxt_q.sel[0] = q_ff.wdata[7:0];
        end
      end else if (q_ff.waddr == `AGPS_OFF_SELB) begin
        if (q_ff.wstrb[0]) begin
          nxt_q.sel[1] = q_ff.wdata[7:0];
        end
      end else if (q_ff.waddr == `AGPS_OFF_SELC) begin
        if (q_ff.wstrb[0]) begin
          nxt_q.sel[2] = q_ff.wdata[7:0];
        end
      end else if (q_ff.waddr >= `AGPS_OFF_RES0 && q_ff.waddr <= `AGPS_OFF_RESN
                   && q_ff.waddr[1:0] == 2'h0) begin
        nxt_q.bresp = `AGPS_RESP_OK; // Results are read-only
      end else if (q_ff.waddr == `AGPS_OFF_DIAG) begin
        nxt_q.bresp = `AGPS_RESP_OK; // Read-only
      end else begin
        nxt_q.bresp = `AGPS_RESP_ERR; // Unmapped
      end
    end
    if (q_ff.bvalid && s_axi_bready) begin
      // Response taken: reopen both channels
      nxt_q.bvalid = 1'b0;
      nxt_q.awrdy = 1'b1;
      nxt_q.wrdy = 1'b1;
    end

    // Bus read: one at a time
    if (s_axi_arvalid && q_ff.arrdy) begin
      nxt_q.arrdy = 1'b0;
      nxt_q.rvalid = 1'b1;
      nxt_q.rresp = `AGPS_RESP_OK;
      nxt_q.rdata = 32'h0000_0000;
      if (s_axi_araddr == `AGPS_OFF_CTRL) begin
        nxt_q.rdata[7:0] = q_ff.ctrl;
      end else if (s_axi_araddr == `AGPS_OFF_STAT) begin
        nxt_q.rdata[0] = q_ff.start;
        nxt_q.rdata[2:1] = q_ff.grp;
        nxt_q.rdata[6:4] = q_ff.pend;
        nxt_q.rdata[11:8] = q_ff.st;
      end else if (s_axi_araddr == `AGPS_OFF_SELA) begin
        nxt_q.rdata[7:0] = q_ff.sel[0];
      end else if (s_axi_araddr == `AGPS_OFF_SELB) begin
        nxt_q.rdata[7:0] = q_ff.sel[1];
      end else if (s_axi_araddr == `AGPS_OFF_SELC) begin
        nxt_q.rdata[7:0] = q_ff.sel[2];
      end else if (s_axi_araddr == `AGPS_OFF_DIAG) begin
        nxt_q.rdata[11:0] = q_ff.diag_res;
      end else if (s_axi_araddr >= `AGPS_OFF_RES0 && s_axi_araddr <= `AGPS_OFF_RESN
                   && s_axi_araddr[1:0] == 2'h0) begin
        nxt_q.rdata[11:0] = q_ff.res[s_axi_araddr[4:2]];
      end else begin
        nxt_q.rresp = `AGPS_RESP_ERR; // Unmapped reads as zero
      end
    end
    if (q_ff.rvalid && s_axi_rready) begin
      nxt_q.rvalid = 1'b0;
      nxt_q.arrdy = 1'b1;
    end

    // Scan control
    if (sw_wr_stat && !q_ff.wdata[0]) begin
      // Forced stop by software: drop everything
      nxt_q.start = 1'b0;
      nxt_q.st = agps_pkg::ST_IDLE;
      nxt_q.pend = 3'h0;
      nxt_q.abort = 1'b1;
    end else if (q_ff.st == agps_pkg::ST_IDLE) begin
      // Waiting: a trigger, a software start or repeat begins a scan
      if (trg[0] || (sw_wr_stat && q_ff.wdata[0])) begin
        st_req = 1'b1;
        st_grp = 2'h0;
      end else if (trg[1]) begin
        st_req = 1'b1;
        st_grp = 2'h1;
      end else if (trg[2]) begin
        st_req = 1'b1;
        st_grp = 2'h2;
      end else if (rpt) begin
        st_req = 1'b1;
        st_grp = low_g;
      end
    end else begin
      // Triggers of lower groups queue only with rescan; own one is ignored
      for (int g = 0; g < 3; g++) begin
        if (trg[g] && 2'(g) > q_ff.grp && rscn && !q_ff.pend[g]) begin
          nxt_q.pend[g] = 1'b1;
          nxt_q.rsm[g] = 4'h0;
        end
      end
      if (group_priority_select && q_ff.grp != 2'h0 && (trg[0] || (trg[1] && q_ff.grp == 2'h2))) begin
        // Higher group pre-empts; unfinished conversion is dropped
        st_req = 1'b1;
        st_grp = trg[0] ? 2'h0 : 2'h1;
        nxt_q.abort = 1'b1;
        if (rscn || (rpt && q_ff.grp == low_g)) begin
          nxt_q.pend[q_ff.grp] = 1'b1;
          // Resume only with rescan; B in three groups needs repeat too
          if (rscn && rsm_en && (q_ff.grp == low_g || rpt)) begin
            nxt_q.rsm[q_ff.grp] = q_ff.ch;
          end else begin
            nxt_q.rsm[q_ff.grp] = 4'h0;
          end
        end else begin
          nxt_q.pend[q_ff.grp] = 1'b0;
        end
      end else begin
        case (q_ff.st)
          agps_pkg::ST_DIAG: begin
            // Diagnosis result, then the channel walk
            if (done_ok) begin
              nxt_q.diag_res = cv.result;
              nxt_q.st = agps_pkg::ST_SEEK;
            end
          end
          agps_pkg::ST_CONV: begin
            // Store result and step upward
            if (done_ok) begin
              nxt_q.res[q_ff.cch] = cv.result;
              nxt_q.ch = q_ff.ch + 4'h1;
              nxt_q.st = agps_pkg::ST_SEEK;
            end
          end
          agps_pkg::ST_SEEK: begin
            if (nch != 4'h8) begin
              // Next selected channel in ascending order
              nxt_q.ch = nch;
              nxt_q.cch = nch[2:0];
              nxt_q.go = 1'b1;
              nxt_q.diag = 1'b0;
              nxt_q.st = agps_pkg::ST_CONV;
            end else begin
              // Scan of this group ended
              nxt_q.irq_a = q_ff.ctrl[`AGPS_B_IE] && q_ff.grp != 2'h1;
              nxt_q.irq_b = q_ff.ctrl[`AGPS_B_GBIE] && q_ff.grp == 2'h1;
              if (q_ff.pend[0]) begin
                st_req = 1'b1;
                st_grp = 2'h0;
              end else if (q_ff.pend[1]) begin
                st_req = 1'b1;
                st_grp = 2'h1;
              end else if (q_ff.pend[2] && group_c_enable) begin
                st_req = 1'b1;
                st_grp = 2'h2;
              end else if (rpt) begin
                st_req = 1'b1;
                st_grp = low_g;
              end else begin
                nxt_q.start = 1'b0;
                nxt_q.st = agps_pkg::ST_IDLE;
              end
            end
          end
          default: begin
            nxt_q.st = agps_pkg::ST_IDLE;
          end
        endcase
      end
    end

    // Begin a group scan, at its saved channel when pending
    if (st_req) begin
      st_from = q_ff.pend[st_grp] ? q_ff.rsm[st_grp] : 4'h0;
      nxt_q.pend[st_grp] = 1'b0;
      nxt_q.grp = st_grp;
      nxt_q.ch = st_from;
      nxt_q.start = 1'b1;
      if (diag_en) begin
        nxt_q.go = 1'b1;
        nxt_q.diag = 1'b1;
        nxt_q.cch = 3'h0;
        nxt_q.st = agps_pkg::ST_DIAG;
      end else begin
        nxt_q.st = agps_pkg::ST_SEEK;
      end
    end
    if (!rscn) begin
      // Without rescan only the repeating lowest group may stay pending
      for (int g = 0; g < 3; g++) begin
        if (!(rpt && 2'(g) == low_g)) begin
          nxt_q.pend[g] = 1'b0;
        end
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_ff <= '0;
      q_ff.ctrl <= `AGPS_CTRL_RST;
      q_ff.sel <= {3{`AGPS_SEL_RST}};
      q_ff.st <= agps_pkg::ST_IDLE;
      q_ff.awrdy <= 1'b1;
      q_ff.wrdy <= 1'b1;
      q_ff.arrdy <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign s_axi_awready = q_ff.awrdy;
  assign s_axi_wready = q_ff.wrdy;
  assign s_axi_bvalid = q_ff.bvalid;
  assign s_axi_bresp = q_ff.bresp;
  assign s_axi_arready = q_ff.arrdy;
  assign s_axi_rvalid = q_ff.rvalid;
  assign s_axi_rdata = q_ff.rdata;
  assign s_axi_rresp = q_ff.rresp;
  assign conversion_start_flag = q_ff.start;
  assign scan_end_irq = q_ff.irq_a;
  assign group_b_scan_end_irq = q_ff.irq_b;
endmodule : agps_sequencer

// ### tb/agps_trig_src.sv
// Far-side model: per-group trigger sources and the analog sample source.
// Assumes the bench calls fire() from its own process on aclk.
`timescale 1ns/10ps
module agps_trig_src (
  input wire logic aclk,
  input wire logic [2:0] analog_input_channel,
  output logic [2:0] trig,
  output logic [11:0] sample_data
);
  // Trigger lines, one bit a group, idle low
  initial begin
    trig = 3'h0;
  end
  // Sample level follows the selected channel so each result is traceable
  assign sample_data = {9'h150, analog_input_channel};
  // One-cycle trigger pulse for group g (0 A, 1 B, 2 C)
  task automatic fire(input int g);
    @(posedge aclk);
    trig[g] <= 1'b1;
    @(posedge aclk);
    trig[g] <= 1'b0;
  endtask : fire
endmodule : agps_trig_src

// ### tb/agps_seq_sva.sv
// Checker for the scan sequencer: bus handshakes, pulses, start flag.
// Assumes it is bound to the sequencer top and sees only its ports.
`timescale 1ns/10ps
module agps_seq_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trig_a,
  input wire logic conversion_start_flag,
  input wire logic scan_end_irq,
  input wire logic group_b_scan_end_irq
);
  // All checks on aclk, quiet during reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write answered two edges after both halves are taken together
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  // Write response holds until taken
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  // No new write accepted while a response waits
  a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  // Read data follows the address by one cycle
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  // Read data holds until taken
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  // No new read accepted while data waits
  a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during data");
  // Group A trigger sets the start flag on the next cycle
  a_trig_start: assert property (trig_a |=> conversion_start_flag)
    else $error("start flag not set by trigger");
  // Scan-end requests are single-cycle pulses
  a_irq_pulse: assert property (scan_end_irq |=> !scan_end_irq)
    else $error("scan end request too long");
  a_gbirq_pulse: assert property (group_b_scan_end_irq |=> !group_b_scan_end_irq)
    else $error("group b request too long");
  // Main scenarios
  c_irq: cover property (scan_end_irq);
  c_gbirq: cover property (group_b_scan_end_irq);
  c_preempt: cover property (trig_a && conversion_start_flag);
endmodule : agps_seq_sva
bind agps_sequencer agps_seq_sva i_agps_seq_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .trig_a(trig_a), .conversion_start_flag(conversion_start_flag),
  .scan_end_irq(scan_end_irq), .group_b_scan_end_irq(group_b_scan_end_irq));

// ### tb/test_adc_group_priority_scan_sequencer.sv
// Self-checking bench for the group priority scan sequencer.
// Assumes the far-side model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_adc_group_priority_scan_sequencer;
  logic aclk = 1'b0; // 10 MHz clock
  logic aresetn = 1'b0; // Held low at start
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb; // Write strobes
  logic [1:0] br; // Last write response
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, gbirq, flag, diag_on;
  logic [1:0] bresp, rresp;
  logic [2:0] trig, mux;
  logic [11:0] sample;
  logic [31:0] rd; // Last read word
  logic [1:0] rr; // Last read response
  int checks = 0, mismatches = 0;
  // Clock
  always #50 aclk = ~aclk;
  agps_sequencer i_agps_sequencer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trig_a(trig[0]),
    .trig_b(trig[1]), .trig_c(trig[2]), .sample_data(sample),
    .analog_input_channel(mux), .self_diagnosis_active(diag_on),
    .conversion_start_flag(flag), .scan_end_irq(irq), .group_b_scan_end_irq(gbirq));
  agps_trig_src i_agps_trig_src (.aclk(aclk), .analog_input_channel(mux),
    .trig(trig), .sample_data(sample));
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  // Register write: both halves offered, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    br = bresp;
    bready <= 1'b0;
  endtask : wr
  // Register read into rd and rr
  task automatic rdw(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata; rr = rresp;
    rready <= 1'b0;
  endtask : rdw
  // Wait for a scan-end pulse, returning cycles waited
  task automatic wait_irq(input bit gb, output int n);
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if ((gb ? gbirq : irq) === 1'b1) break;
    end
    `CHK("irq seen", 1'b1, n < 400)
  endtask : wait_irq
  // Result word expected for channel n
  function automatic logic [31:0] exp_res(input int n);
    return {20'h0, 9'h150, n[2:0]};
  endfunction : exp_res
  // Reset values, write-read, unmapped address
  task automatic t_regs();
    rdw(8'h00); `CHK("ctrl reset", 32'h0, rd)
    rdw(8'h04); `CHK("status reset", 32'h100, rd)
    rdw(8'h40); `CHK("unmapped resp", 2'h2, rr)
    wr(8'h08, 32'h01); rdw(8'h08); `CHK("sel a", 32'h01, rd)
    // Strobe off: the write is answered but changes nothing
    wstrb <= 4'h0;
    wr(8'h08, 32'h02);
    wstrb <= 4'hF;
    rdw(8'h08);
    `CHK("strobe off", 32'h01, rd)
    wr(8'h40, 32'h0);
    `CHK("unmapped wr", 2'h2, br)
  endtask : t_regs
  // Group B cut by A without rescan; partial result dropped
  task automatic t_preempt();
    int n;
    wr(8'h00, 32'hC1); wr(8'h0C, 32'h0E);
    i_agps_trig_src.fire(1);
    repeat (10) @(posedge aclk);
    i_agps_trig_src.fire(0);
    @(posedge aclk);
    `CHK("flag kept", 1'b1, flag)
    wait_irq(1'b0, n);
    `CHK("flag clear", 1'b0, flag)
    rdw(8'h24); `CHK("cut ch1 kept", 32'h0, rd)
    rdw(8'h04); `CHK("no pending", 32'h0, rd & 32'h71)
  endtask : t_preempt
  // Single group A scan with request enabled
  task automatic t_single();
    int n;
    wr(8'h00, 32'h40);
    i_agps_trig_src.fire(0);
    @(posedge aclk);
    `CHK("flag set", 1'b1, flag)
    wait_irq(1'b0, n);
    `CHK("flag done", 1'b0, flag)
    rdw(8'h20); `CHK("res ch0", exp_res(0), rd)
  endtask : t_single
  // Rescan: B queued during A, then A cuts the B rescan
  task automatic t_rescan();
    int n;
    wr(8'h00, 32'hC5);
    i_agps_trig_src.fire(0);
    repeat (4) @(posedge aclk);
    i_agps_trig_src.fire(1);
    wait_irq(1'b0, n);
    `CHK("flag held", 1'b1, flag)
    repeat (30) @(posedge aclk);
    i_agps_trig_src.fire(0);
    wait_irq(1'b0, n);
    `CHK("flag rescan", 1'b1, flag)
    wait_irq(1'b1, n);
    `CHK("flag end", 1'b0, flag)
    for (int c = 1; c < 4; c++) begin
      rdw(8'h20 + 8'(4 * c)); `CHK("res b", exp_res(c), rd)
    end
  endtask : t_rescan
  // Three groups with resume: C continues at its cut channel
  task automatic t_three();
    int n;
    // Repeat stays off, so the start flag is never cleared by hand
    wr(8'h00, 32'h4F); wr(8'h10, 32'h18);
    rdw(8'h00); `CHK("ctrl", 32'h4F, rd)
    i_agps_trig_src.fire(2);
    repeat (35) @(posedge aclk);
    i_agps_trig_src.fire(0);
    wait_irq(1'b0, n);
    `CHK("flag c pend", 1'b1, flag)
    wait_irq(1'b0, n);
    `CHK("resume short", 1'b1, n < 40)
    rdw(8'h30); `CHK("res ch4", exp_res(4), rd)
  endtask : t_three
  // Group B repeats on its own; repeat goes off before the forced stop
  task automatic t_repeat();
    int n;
    wr(8'h0C, 32'h02);
    wr(8'h00, 32'h91);
    wait_irq(1'b1, n);
    wait_irq(1'b1, n);
    `CHK("repeat flag", 1'b1, flag)
    `CHK("repeat period", 1'b1, n < 30)
    wr(8'h00, 32'h81);
    wr(8'h04, 32'h0);
    `CHK("stopped", 1'b0, flag)
    repeat (30) @(posedge aclk);
    `CHK("no restart", 1'b0, flag)
  endtask : t_repeat
  // Self-diagnosis conversion runs before the first channel
  task automatic t_diag();
    int n;
    wr(8'h00, 32'h60);
    i_agps_trig_src.fire(0);
    repeat (5) @(posedge aclk);
    `CHK("diag first", 1'b1, diag_on)
    `CHK("diag mux", 3'h0, mux)
    wait_irq(1'b0, n);
    `CHK("diag then ch", 1'b0, diag_on)
    rdw(8'h14);
    `CHK("diag res", exp_res(0), rd)
  endtask : t_diag
  // Main sequence
  initial begin
    awaddr <= 8'h00;
    araddr <= 8'h00;
    wdata <= 32'h0000_0000;
    wstrb <= 4'hF;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_preempt();
    t_single();
    t_rescan();
    t_three();
    t_repeat();
    t_diag();
    stop_test();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    stop_test();
  end
endmodule : test_adc_group_priority_scan_sequencer
